// [core/csr_pkg.sv]
/*
  Package for the CPU state register block: widths, flag positions, reset
  values and the command codes that the sequencer uses.
  Assumes a single core clock and an active-low asynchronous reset.
*/
package csr_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  // Condition flag bit positions.
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_I = 3;
  localparam int FLAG_H = 4;
  // Reset values.
  localparam logic [7:0] FLAGS_RESET = 8'hE8;
  localparam logic [7:0] FLAGS_FIXED = 8'hE0;
  localparam logic [15:0] SP_RESET = 16'h017F;
  localparam logic [15:0] SP_FIXED_MASK = 16'hFFC0;
  localparam logic [15:0] SP_LOW_MASK = 16'h003F;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;
  // Stack usage of context saves.
  localparam logic [2:0] CALL_BYTES = 3'h2;
  localparam logic [2:0] IRQ_BYTES = 3'h5;
  // Destination select for a plain register write.
  typedef enum logic [2:0] {
    CSR_DST_NONE, CSR_DST_ACC, CSR_DST_IDX_X, CSR_DST_IDX_Y,
    CSR_DST_PC_LO, CSR_DST_PC_HI, CSR_DST_SP_LO, CSR_DST_FLAGS
  } csr_dst_e;
  // ALU flag update class.
  typedef enum logic [1:0] {
    CSR_FUPD_NONE, CSR_FUPD_NZ, CSR_FUPD_NZC, CSR_FUPD_HNZC
  } csr_fupd_e;
endpackage

// [core/csr_stk_if.sv]
/*
  Interface carrying stack pointer commands between the main register
  block and the stack pointer module. Assumes one clock domain.
*/
`timescale 1ns/1ps
interface csr_stk_if;
  logic push;
  logic pop;
  logic rst_sp;
  logic wr_lo;
  logic [7:0] wr_data;
  logic [15:0] sp;
  modport ctrl (output push, output pop, output rst_sp, output wr_lo, output wr_data,
                input sp);
  modport stk (input push, input pop, input rst_sp, input wr_lo, input wr_data,
               output sp);
endinterface

// [core/csr_stack_ptr.sv]
/*
  Stack pointer of the CPU state block: ten upper bits fixed, six low bits
  counting inside a 64-byte stack.
  Assumes push and pop are never asked in the same cycle as each other.
*/
`timescale 1ns/1ps
module csr_stack_ptr (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  csr_stk_if.stk stk
);
  import csr_pkg::*;

  logic [5:0] sp_low_ff;

  // --------------------------------------------------------------------
  // Low six bits
  // --------------------------------------------------------------------
  // Wrap is silent in both directions: six-bit arithmetic drops the carry.
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sp_low_ff <= SP_RESET[5:0];
    end else if (stk.rst_sp) begin
      sp_low_ff <= SP_RESET[5:0];
    end else if (stk.wr_lo) begin
      sp_low_ff <= stk.wr_data[5:0];
    end else if (stk.push) begin
      sp_low_ff <= sp_low_ff - 6'h01;
    end else if (stk.pop) begin
      sp_low_ff <= sp_low_ff + 6'h01;
    end
  end

  assign stk.sp = (SP_RESET & SP_FIXED_MASK) | {10'h000, sp_low_ff};
endmodule

// [core/csr_cpu_state.sv]
/*
  CPU architectural state: accumulator, index registers, program counter,
  condition flags and stack pointer, plus the interrupt entry and return
  sequences that save and restore context through the stack.
  Assumes the instruction sequencer drives the command ports and that the
  data memory answers a read in the same cycle (combinational read data).
*/
//
// Overview of operation
// - Eight-bit accumulator, reached by instructions only.
// - Two eight-bit index registers for addressing.
// - Second index register never saved on interrupts.
// - Sixteen-bit program counter with separate bytes.
// - Eight-bit flags; top three and mask reset high.
// - Half carry from bit three on add.
// - Mask set by entry or instruction; blocks maskables.
// - Masked requests stay pending until unmasked.
// - Return clears mask; pending taken at once.
// - Negative flag copies result top bit.
// - Zero flag set when result is zero.
// - Carry from arithmetic, set/reset, shifts, bit tests.
// - Stack pointer points free; post-decrement, pre-increment.
// - Upper ten bits fixed; reset sets low six.
// - Stack low byte loadable; upper bits kept.
// - Stack wraps silently both ways.
// - Entry stores program counter low byte first.
// - Call uses two bytes, interrupt five.
// - Entry saves context, sets mask, loads vector.
`timescale 1ns/1ps
module csr_cpu_state (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Plain register write from the sequencer.
  input wire csr_pkg::csr_dst_e i_wr_dst,
  input wire logic [7:0] i_wr_data,
  // ALU result and flag update.
  input wire csr_pkg::csr_fupd_e i_fupd,
  input wire logic [7:0] i_alu_result,
  input wire logic i_alu_carry,
  input wire logic i_alu_half,
  // Individual flag and stack pointer instructions.
  input wire logic i_set_mask_instruction,
  input wire logic i_clear_mask_instruction,
  input wire logic i_set_carry_instruction,
  input wire logic i_reset_carry_instruction,
  input wire logic i_reset_stack_pointer_instruction,
  // Program counter flow.
  input wire logic i_pc_inc,
  input wire logic i_pc_load,
  input wire logic [15:0] i_pc_target,
  // Subroutine call and return.
  input wire logic i_call,
  input wire logic i_ret,
  // Interrupts.
  input wire logic i_irq_req,
  input wire logic [15:0] i_irq_vector,
  input wire logic i_trap,
  input wire logic [15:0] i_trap_vector,
  input wire logic i_interrupt_return_instruction,
  input wire logic i_insn_end,
  // Stack memory port.
  input wire logic [7:0] i_mem_rdata,
  output logic o_mem_we,
  output logic o_mem_re,
  output logic [15:0] o_mem_addr,
  output logic [7:0] o_mem_wdata,
  // State visible to the core.
  output logic [7:0] o_accumulator,
  output logic [7:0] o_index_x,
  output logic [7:0] o_index_y,
  output logic [15:0] o_program_counter,
  output logic [7:0] o_condition_flags,
  output logic [15:0] o_stack_pointer,
  output logic o_irq_pending,
  output logic o_busy
);
  import csr_pkg::*;

  typedef enum logic [1:0] {CSR_IDLE, CSR_SAVE, CSR_LOAD} csr_seq_e;
  typedef enum logic [1:0] {CSR_K_IRQ, CSR_K_CALL, CSR_K_INTERRUPT_RETURN_INSTRUCTION, CSR_K_RET} csr_kind_e;

  logic [7:0] acc_ff;
  logic [7:0] idx_x_ff;
  logic [7:0] idx_y_ff;
  logic [15:0] pc_ff;
  logic [4:0] flags_ff;
  logic irq_pend_ff;
  csr_seq_e seq_ff;
  csr_kind_e kind_ff;
  logic [2:0] step_ff;
  logic [15:0] vec_ff;
  logic take_irq;
  logic take_trap;
  logic seq_push;
  logic seq_pop;
  logic [7:0] save_byte;
  logic [2:0] nxt_last;

  csr_stk_if stk_bus ();

  csr_stack_ptr u_stack_ptr (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .stk(stk_bus.stk)
  );

  // --------------------------------------------------------------------
  // Interrupt acceptance
  // --------------------------------------------------------------------
  // A request is latched so that a masked one is never dropped.
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_pend_ff <= 1'b0;
    end else if (i_irq_req) begin
      irq_pend_ff <= 1'b1;
    end else if (take_irq) begin
      irq_pend_ff <= 1'b0;
    end
  end

  // Taken only at an instruction boundary; the trap ignores the mask.
  assign take_trap = i_insn_end && seq_ff == CSR_IDLE && i_trap;
  assign take_irq = i_insn_end && seq_ff == CSR_IDLE && !i_trap
                    && irq_pend_ff && !flags_ff[FLAG_I];

  function automatic logic [2:0] seq_len(input csr_kind_e k);
    if (k == CSR_K_IRQ || k == CSR_K_INTERRUPT_RETURN_INSTRUCTION) begin
      return IRQ_BYTES;
    end
    return CALL_BYTES;
  endfunction

  // --------------------------------------------------------------------
  // Save and restore sequencer
  // --------------------------------------------------------------------
  // Start priority is trap or request, then call, then return from
  // interrupt, then plain return; the kind and vector blocks follow it.
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      seq_ff <= CSR_IDLE;
    end else begin
      unique case (seq_ff)
        CSR_IDLE: begin
          if (take_trap || take_irq || i_call) begin
            seq_ff <= CSR_SAVE;
          end else if (i_interrupt_return_instruction || i_ret) begin
            seq_ff <= CSR_LOAD;
          end
        end
        CSR_SAVE, CSR_LOAD: begin
          if (step_ff == nxt_last) begin
            seq_ff <= CSR_IDLE;
          end
        end
        default: begin
          seq_ff <= CSR_IDLE;
        end
      endcase
    end
  end

  // The step count restarts in idle, so a new sequence may begin in the
  // very cycle after the previous one has ended.
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      step_ff <= 3'h0;
    end else if (seq_ff == CSR_IDLE) begin
      step_ff <= 3'h0;
    end else begin
      step_ff <= step_ff + 3'h1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      kind_ff <= CSR_K_IRQ;
    end else if (seq_ff == CSR_IDLE) begin
      if (take_trap || take_irq) begin
        kind_ff <= CSR_K_IRQ;
      end else if (i_call) begin
        kind_ff <= CSR_K_CALL;
      end else if (i_interrupt_return_instruction) begin
        kind_ff <= CSR_K_INTERRUPT_RETURN_INSTRUCTION;
      end else if (i_ret) begin
        kind_ff <= CSR_K_RET;
      end
    end
  end

  // The target is captured at the start, since the sequencer is free to
  // move its target and vector inputs while the context is being saved.
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      vec_ff <= PC_RESET;
    end else if (seq_ff == CSR_IDLE) begin
      if (take_trap || take_irq) begin
        vec_ff <= take_trap ? i_trap_vector : i_irq_vector;
      end else if (i_call) begin
        vec_ff <= i_pc_target;
      end
    end
  end

  assign nxt_last = seq_len(kind_ff) - 3'h1;
  assign seq_push = seq_ff == CSR_SAVE;
  assign seq_pop = seq_ff == CSR_LOAD;

  // Save order: program counter low, high, then X, A, flags; Y never.
  always_comb begin
    unique case (step_ff)
      3'h0: save_byte = pc_ff[7:0];
      3'h1: save_byte = pc_ff[15:8];
      3'h2: save_byte = idx_x_ff;
      3'h3: save_byte = acc_ff;
      3'h4: save_byte = {FLAGS_FIXED[7:5], flags_ff};
      default: save_byte = REG_RESET;
    endcase
  end

  // --------------------------------------------------------------------
  // Stack control
  // --------------------------------------------------------------------
  // Pop is pre-increment: memory is read at the incremented address in the same
  // cycle, and the pointer moves there at the closing edge, hence sp + 1 here.
  assign stk_bus.push = seq_push;
  assign stk_bus.pop = seq_pop;
  assign stk_bus.rst_sp = i_reset_stack_pointer_instruction;
  assign stk_bus.wr_lo = i_wr_dst == CSR_DST_SP_LO && seq_ff == CSR_IDLE;
  assign stk_bus.wr_data = i_wr_data;

  assign o_mem_we = seq_push;
  assign o_mem_re = seq_pop;
  assign o_mem_addr = seq_pop
    ? ((stk_bus.sp & SP_FIXED_MASK) | ((stk_bus.sp + 16'h0001) & SP_LOW_MASK))
    : stk_bus.sp;
  assign o_mem_wdata = save_byte;

  // --------------------------------------------------------------------
  // Accumulator and index registers
  // --------------------------------------------------------------------
  // Restore order is the reverse of the save: flags, A, X, PC high, low.
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      acc_ff <= REG_RESET;
    end else if (seq_pop && kind_ff == CSR_K_INTERRUPT_RETURN_INSTRUCTION && step_ff == 3'h1) begin
      acc_ff <= i_mem_rdata;
    end else if (i_wr_dst == CSR_DST_ACC && seq_ff == CSR_IDLE) begin
      acc_ff <= i_wr_data;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      idx_x_ff <= REG_RESET;
    end else if (seq_pop && kind_ff == CSR_K_INTERRUPT_RETURN_INSTRUCTION && step_ff == 3'h2) begin
      idx_x_ff <= i_mem_rdata;
    end else if (i_wr_dst == CSR_DST_IDX_X && seq_ff == CSR_IDLE) begin
      idx_x_ff <= i_wr_data;
    end
  end

  // The second index register has no stack path at all.
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      idx_y_ff <= REG_RESET;
    end else if (i_wr_dst == CSR_DST_IDX_Y && seq_ff == CSR_IDLE) begin
      idx_y_ff <= i_wr_data;
    end
  end

  // --------------------------------------------------------------------
  // Program counter
  // --------------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pc_ff <= PC_RESET;
    end else if (seq_push && step_ff == nxt_last) begin
      pc_ff <= vec_ff;
    end else if (seq_pop && step_ff == nxt_last) begin
      pc_ff[7:0] <= i_mem_rdata;
    end else if (seq_pop && step_ff == nxt_last - 3'h1) begin
      pc_ff[15:8] <= i_mem_rdata;
    end else if (seq_ff == CSR_IDLE && i_pc_load) begin
      pc_ff <= i_pc_target;
    end else if (seq_ff == CSR_IDLE && i_wr_dst == CSR_DST_PC_LO) begin
      pc_ff[7:0] <= i_wr_data;
    end else if (seq_ff == CSR_IDLE && i_wr_dst == CSR_DST_PC_HI) begin
      pc_ff[15:8] <= i_wr_data;
    end else if (seq_ff == CSR_IDLE && i_pc_inc) begin
      pc_ff <= pc_ff + 16'h0001;
    end
  end

  // --------------------------------------------------------------------
  // Condition flags
  // --------------------------------------------------------------------
  // Only the low five bits are stored; the top three always read one.
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      flags_ff <= FLAGS_RESET[4:0];
    end else if (seq_push && kind_ff == CSR_K_IRQ && step_ff == nxt_last) begin
      flags_ff[FLAG_I] <= 1'b1;
    end else if (seq_pop && kind_ff == CSR_K_INTERRUPT_RETURN_INSTRUCTION && step_ff == 3'h0) begin
      // The low five bits of the restored byte are taken, with the mask bit forced clear.
      flags_ff <= {i_mem_rdata[4], 1'b0, i_mem_rdata[2:0]};
    end else if (seq_ff == CSR_IDLE) begin
      if (i_wr_dst == CSR_DST_FLAGS) begin
        flags_ff <= i_wr_data[4:0];
      end else begin
        if (i_fupd != CSR_FUPD_NONE) begin
          flags_ff[FLAG_N] <= i_alu_result[7];
          flags_ff[FLAG_Z] <= i_alu_result == 8'h00;
        end
        if (i_fupd == CSR_FUPD_NZC || i_fupd == CSR_FUPD_HNZC) begin
          flags_ff[FLAG_C] <= i_alu_carry;
        end
        if (i_fupd == CSR_FUPD_HNZC) begin
          flags_ff[FLAG_H] <= i_alu_half;
        end
        if (i_set_carry_instruction) begin
          flags_ff[FLAG_C] <= 1'b1;
        end else if (i_reset_carry_instruction) begin
          flags_ff[FLAG_C] <= 1'b0;
        end
        if (i_set_mask_instruction) begin
          flags_ff[FLAG_I] <= 1'b1;
        end else if (i_clear_mask_instruction) begin
          flags_ff[FLAG_I] <= 1'b0;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign o_accumulator = acc_ff;
  assign o_index_x = idx_x_ff;
  assign o_index_y = idx_y_ff;
  assign o_program_counter = pc_ff;
  assign o_condition_flags = {FLAGS_FIXED[7:5], flags_ff};
  assign o_stack_pointer = stk_bus.sp;
  assign o_irq_pending = irq_pend_ff;
  assign o_busy = seq_ff != CSR_IDLE;
endmodule

// [tb/csr_stack_mem.sv]
/*
  Stack memory beside the CPU state block, read combinationally.
  Assumes only the 64-byte stack window is ever addressed.
*/
`timescale 1ns/1ps
module csr_stack_mem (
  input wire logic i_core_clk,
  input wire logic i_we,
  input wire logic i_re,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] mem_ff [0:255];
  logic [7:0] last_ff;
  always_ff @(posedge i_core_clk) begin
    if (i_we) mem_ff[i_addr[7:0]] <= i_wdata;
    if (i_re) last_ff <= o_rdata;
  end
  // Outside a read the bus shows the inverse of the last byte, so a late sample is caught.
  assign o_rdata = i_re ? mem_ff[i_addr[7:0]] : ~last_ff;
endmodule

// [tb/csr_cpu_state_checker.sv]
/*
  Assertions on the ports of the CPU state block, bound to its top module.
  Assumes one core clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module csr_cpu_state_checker (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire csr_pkg::csr_dst_e i_wr_dst,
  input wire csr_pkg::csr_fupd_e i_fupd,
  input wire logic [7:0] i_alu_result,
  input wire logic i_alu_half,
  input wire logic i_reset_stack_pointer_instruction,
  input wire logic i_interrupt_return_instruction,
  input wire logic i_insn_end,
  input wire logic o_mem_we,
  input wire logic o_mem_re,
  input wire logic [15:0] o_mem_addr,
  input wire logic [7:0] o_mem_wdata,
  input wire logic [15:0] o_program_counter,
  input wire logic [7:0] o_condition_flags,
  input wire logic [15:0] o_stack_pointer,
  input wire logic o_irq_pending,
  input wire logic o_busy
);
  import csr_pkg::*;
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);
  flag_top_a: assert property (o_condition_flags[7:5] == 3'h7)
    else $error("flag top bits not set");
  sp_upper_a: assert property (o_stack_pointer[15:6] == 10'h005)
    else $error("stack pointer upper bits moved");
  push_pcl_first_a: assert property (o_mem_we && !$past(o_busy) |->
    o_mem_addr == o_stack_pointer && o_mem_wdata == o_program_counter[7:0])
    else $error("first push not low pc at sp");
  pop_above_a: assert property (o_mem_re && !$past(o_busy) |->
    o_mem_addr == {10'h005, o_stack_pointer[5:0] + 6'h01})
    else $error("first pop not at sp plus one");
  irq_entry_a: assert property (i_insn_end && o_irq_pending && !o_condition_flags[3]
    && !o_busy |=> o_mem_we [*5] ##1 (!o_busy && !o_mem_we && o_condition_flags[3]
    && o_stack_pointer[5:0] == $past(o_stack_pointer[5:0], 6) - 6'h05))
    else $error("interrupt entry wrong");
  pending_held_a: assert property (o_irq_pending && o_condition_flags[3] |=> o_irq_pending)
    else $error("masked request lost");
  interrupt_return_instruction_restore_a: assert property (i_interrupt_return_instruction && !i_insn_end
    && !o_busy |=> o_mem_re [*5] ##1 (!o_busy && !o_condition_flags[3]))
    else $error("return sequence wrong");
  alu_flags_a: assert property (!o_busy && i_fupd == CSR_FUPD_HNZC &&
    i_wr_dst == CSR_DST_NONE |=> o_condition_flags[4:1] == {$past(i_alu_half),
    o_condition_flags[3], $past(i_alu_result[7]), $past(i_alu_result) == 8'h00})
    else $error("alu flags wrong");
  sp_reset_a: assert property (i_reset_stack_pointer_instruction && !o_busy |=>
    o_stack_pointer == SP_RESET)
    else $error("stack pointer not reset");
  cover property (o_mem_we && !$past(o_busy));
  cover property (o_mem_re && !$past(o_busy));
  cover property (o_irq_pending && o_condition_flags[3] && i_insn_end);
endmodule
bind csr_cpu_state csr_cpu_state_checker chk_u (.i_core_clk, .i_rstn, .i_wr_dst, .i_fupd,
  .i_alu_result, .i_alu_half, .i_reset_stack_pointer_instruction,
  .i_interrupt_return_instruction, .i_insn_end, .o_mem_we, .o_mem_re, .o_mem_addr,
  .o_mem_wdata, .o_program_counter, .o_condition_flags, .o_stack_pointer, .o_irq_pending,
  .o_busy);

// [tb/test_cpu_state_registers.sv]
/*
  Self-checking bench for the CPU state block with a stack memory model.
  Assumes commands are taken at the edge after they are driven.
*/
`timescale 1ns/1ps
module test_cpu_state_registers;
  import csr_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_rstn = 1'b0;
  csr_dst_e i_wr_dst;
  csr_fupd_e i_fupd;
  logic [7:0] i_wr_data, i_alu_result, i_mem_rdata;
  logic [15:0] i_pc_target, i_irq_vector, i_trap_vector;
  logic i_alu_carry, i_alu_half, i_set_mask_instruction, i_clear_mask_instruction;
  logic i_set_carry_instruction, i_reset_carry_instruction, i_reset_stack_pointer_instruction;
  logic i_pc_inc, i_pc_load, i_call, i_ret, i_irq_req, i_trap;
  logic i_interrupt_return_instruction, i_insn_end;
  logic o_mem_we, o_mem_re, o_busy, o_irq_pending;
  logic [15:0] o_mem_addr, o_program_counter, o_stack_pointer;
  logic [7:0] o_mem_wdata, o_accumulator, o_index_x, o_index_y, o_condition_flags;
  int err_total = 0;
  int num_checks = 0;
  csr_cpu_state uut (.i_core_clk, .i_rstn, .i_wr_dst, .i_wr_data, .i_fupd, .i_alu_result,
    .i_alu_carry, .i_alu_half, .i_set_mask_instruction, .i_clear_mask_instruction,
    .i_set_carry_instruction, .i_reset_carry_instruction, .i_reset_stack_pointer_instruction,
    .i_pc_inc, .i_pc_load, .i_pc_target, .i_call, .i_ret, .i_irq_req, .i_irq_vector, .i_trap,
    .i_trap_vector, .i_interrupt_return_instruction, .i_insn_end, .i_mem_rdata, .o_mem_we,
    .o_mem_re, .o_mem_addr, .o_mem_wdata, .o_accumulator, .o_index_x, .o_index_y,
    .o_program_counter, .o_condition_flags, .o_stack_pointer, .o_irq_pending, .o_busy);
  csr_stack_mem mem (.i_core_clk, .i_we(o_mem_we), .i_re(o_mem_re), .i_addr(o_mem_addr),
    .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));
  always #20 i_core_clk = ~i_core_clk;
  task tally_and_finish;
    if (err_total == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task clr;
    i_wr_dst <= CSR_DST_NONE;
    i_fupd <= CSR_FUPD_NONE;
    {i_set_mask_instruction, i_clear_mask_instruction, i_set_carry_instruction,
     i_reset_carry_instruction, i_reset_stack_pointer_instruction, i_pc_inc, i_pc_load,
     i_call, i_ret, i_irq_req, i_trap, i_interrupt_return_instruction, i_insn_end} <= '0;
  endtask
  // Every command lasts exactly one edge; checks run at the falling edge after it.
  task go;
    @(posedge i_core_clk);
    clr();
    @(negedge i_core_clk);
  endtask
  task wait_idle;
    int n;
    n = 0;
    while (o_busy !== 1'b0 && n < 20) begin
      @(negedge i_core_clk);
      n++;
    end
    chk("busy", {15'h0000, o_busy}, 16'h0000);
  endtask
  task wr(input csr_dst_e d, input logic [7:0] v);
    @(posedge i_core_clk);
    i_wr_dst <= d;
    i_wr_data <= v;
    go();
  endtask
  task alu(input csr_fupd_e m, input logic [7:0] r, input logic c, input logic h);
    @(posedge i_core_clk);
    i_fupd <= m;
    i_alu_result <= r;
    i_alu_carry <= c;
    i_alu_half <= h;
    go();
  endtask
  task interrupt_return_instruction;
    @(posedge i_core_clk);
    i_interrupt_return_instruction <= 1'b1;
    go();
    wait_idle();
  endtask
  task t_reset;
    chk("regs", {o_accumulator, o_index_x}, 16'h0000);
    chk("pc", o_program_counter, 16'h0000);
    chk("flags", o_condition_flags, 16'h00E8);
    chk("sp", o_stack_pointer, 16'h017F);
  endtask
  task t_regs;
    wr(CSR_DST_ACC, 8'hA5);
    wr(CSR_DST_IDX_X, 8'h3C);
    wr(CSR_DST_IDX_Y, 8'hC3);
    wr(CSR_DST_PC_LO, 8'h34);
    wr(CSR_DST_PC_HI, 8'h12);
    wr(CSR_DST_SP_LO, 8'hC2);
    wr(CSR_DST_FLAGS, 8'h1F);
    chk("flags", o_condition_flags, 16'h00FF);
    wr(CSR_DST_FLAGS, 8'h08);
    chk("acc", o_accumulator, 16'h00A5);
    chk("idx", {o_index_x, o_index_y}, 16'h3CC3);
    chk("pc", o_program_counter, 16'h1234);
    chk("sp", o_stack_pointer, 16'h0142);
  endtask
  task t_irq;
    @(posedge i_core_clk);
    i_irq_req <= 1'b1;
    i_irq_vector <= 16'h2000;
    i_insn_end <= 1'b1;
    go();
    chk("masked", {o_busy, o_irq_pending}, 16'h0001);
    @(posedge i_core_clk);
    i_clear_mask_instruction <= 1'b1;
    go();
    @(posedge i_core_clk);
    i_insn_end <= 1'b1;
    go();
    wait_idle();
    chk("pc", o_program_counter, 16'h2000);
    chk("flags", o_condition_flags, 16'h00E8);
    chk("sp", o_stack_pointer, 16'h017D);
    chk("pcl", mem.mem_ff[8'h42], 16'h0034);
    chk("pch_x", {mem.mem_ff[8'h41], mem.mem_ff[8'h40]}, 16'h123C);
    chk("a_cc", {mem.mem_ff[8'h7F], mem.mem_ff[8'h7E]}, 16'hA5E0);
    chk("idx_y", {o_irq_pending, o_index_y}, 16'h00C3);
    wr(CSR_DST_ACC, 8'h00);
    wr(CSR_DST_IDX_X, 8'h00);
    interrupt_return_instruction();
    chk("acc_x", {o_accumulator, o_index_x}, 16'hA53C);
    chk("pc", o_program_counter, 16'h1234);
    chk("sp", o_stack_pointer, 16'h0142);
    chk("flags", o_condition_flags, 16'h00E0);
  endtask
  task t_trap;
    @(posedge i_core_clk);
    i_set_mask_instruction <= 1'b1;
    go();
    @(posedge i_core_clk);
    i_trap <= 1'b1;
    i_trap_vector <= 16'h3000;
    i_irq_req <= 1'b1;
    i_insn_end <= 1'b1;
    go();
    wait_idle();
    chk("trap", o_program_counter, 16'h3000);
    chk("pend", {o_irq_pending, o_stack_pointer[14:0]}, 16'h817D);
    @(posedge i_core_clk);
    i_clear_mask_instruction <= 1'b1;
    go();
    @(posedge i_core_clk);
    i_insn_end <= 1'b1;
    go();
    wait_idle();
    chk("nest", o_program_counter, 16'h2000);
    chk("sp", o_stack_pointer, 16'h0178);
    interrupt_return_instruction();
    interrupt_return_instruction();
    chk("back", o_program_counter, 16'h1234);
  endtask
  task t_call;
    @(posedge i_core_clk);
    i_call <= 1'b1;
    i_pc_target <= 16'h4567;
    go();
    wait_idle();
    chk("pc", o_program_counter, 16'h4567);
    chk("sp", o_stack_pointer, 16'h0140);
    chk("ret", {mem.mem_ff[8'h42], mem.mem_ff[8'h41]}, 16'h3412);
    @(posedge i_core_clk);
    i_ret <= 1'b1;
    go();
    wait_idle();
    @(posedge i_core_clk);
    i_pc_inc <= 1'b1;
    go();
    chk("pc", o_program_counter, 16'h1235);
    chk("sp", o_stack_pointer, 16'h0142);
    @(posedge i_core_clk);
    i_pc_load <= 1'b1;
    i_pc_target <= 16'h5678;
    go();
    chk("pc_load", o_program_counter, 16'h5678);
  endtask
  task t_alu;
    alu(CSR_FUPD_HNZC, 8'h00, 1'b1, 1'b1);
    chk("hnzc", o_condition_flags, 16'h00F3);
    alu(CSR_FUPD_NZ, 8'h80, 1'b0, 1'b0);
    chk("nz", o_condition_flags, 16'h00F5);
    @(posedge i_core_clk);
    i_reset_carry_instruction <= 1'b1;
    go();
    chk("rcf", o_condition_flags, 16'h00F4);
    @(posedge i_core_clk);
    i_set_carry_instruction <= 1'b1;
    go();
    chk("scf", o_condition_flags, 16'h00F5);
    alu(CSR_FUPD_NZC, 8'h01, 1'b0, 1'b1);
    chk("nzc", o_condition_flags, 16'h00F0);
    @(posedge i_core_clk);
    i_reset_stack_pointer_instruction <= 1'b1;
    go();
    chk("rsp", o_stack_pointer, 16'h017F);
  endtask
  initial begin
    clr();
    {i_wr_data, i_alu_result, i_pc_target, i_irq_vector, i_trap_vector, i_alu_carry,
     i_alu_half} <= '0;
    repeat (10) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    @(negedge i_core_clk);
    t_reset();
    t_regs();
    t_irq();
    t_trap();
    t_call();
    t_alu();
    tally_and_finish();
  end
  initial begin
    repeat (3000) @(posedge i_core_clk);
    err_total++;
    tally_and_finish();
  end
endmodule
